// >>> hw/tksp_link.sv
`timescale 1ns/10ps
`include "tksp_regs.svh"

module tksp_link #(
    parameter int unsigned TMO_CYC = (`TKSP_BUS_IDLE_US * 1000) / `TKSP_LCLK_PERIOD_NS
) (
    input  wire logic             lclk,
    input  wire logic             rst_b,
    input  wire logic             serial_clock_i,
    input  wire logic             serial_data_i,
    input  wire logic             key_req_tgl,
    input  wire logic [7:0]       key_data,
    output logic                  key_ack_tgl,
    output logic                  wr_tgl,
    output logic [7:0]            wr_level,
    output tksp_pkg::tksp_od_t    serial_data
);
    import tksp_pkg::*;

    localparam int unsigned ACK_CYC =
        (`TKSP_ACK_MIN_NS + `TKSP_LCLK_PERIOD_NS - 1) / `TKSP_LCLK_PERIOD_NS;

    logic         rs1_q, lrst_b_q;
    logic         scl1_q, scl2_q, scl3_q, sda1_q, sda2_q;
    logic         kr1_q, kr2_q, kr3_q;
    logic [7:0]   keys_q, snap_q, stage_q;
    tksp_lstate_t st_q;
    logic [31:0]  cnt_q;
    logic [3:0]   bit_q;
    logic         wr_q;
    tksp_od_t     sd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // reset and pin synchronisers
    always_ff @(posedge lclk) begin
        rs1_q    <= rst_b;
        lrst_b_q <= rs1_q;
        scl1_q   <= serial_clock_i;
        scl2_q   <= scl1_q;
        scl3_q   <= scl2_q;
        sda1_q   <= serial_data_i;
        sda2_q   <= sda1_q;
        kr1_q    <= key_req_tgl;
        kr2_q    <= kr1_q;
        kr3_q    <= kr2_q;
    end

    // key byte: captured when the request toggle arrives and acknowledged on the same edge
    always_ff @(posedge lclk) begin
        if (!lrst_b_q) begin
            keys_q      <= 8'h00;
            key_ack_tgl <= 1'b0;
        end else begin
            if (kr2_q ^ kr3_q)
                keys_q <= key_data;
            key_ack_tgl <= kr2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit engine
    wire       scl_fall = scl3_q & ~scl2_q;
    wire       dly_done = (cnt_q == ACK_CYC - 1);
    wire       is_start = (bit_q == `TKSP_BIT_START);
    wire       is_end   = (bit_q == `TKSP_BIT_END);
    wire [2:0] idx      = 3'(bit_q - 4'h1);

    always_ff @(posedge lclk) begin
        if (!lrst_b_q) begin
            st_q     <= TKSP_ST_IDLE;
            cnt_q    <= 32'h0;
            bit_q    <= 4'h0;
            wr_q     <= 1'b0;
            sd_q     <= '0;
            snap_q   <= 8'h00;
            stage_q  <= 8'h00;
            wr_tgl   <= 1'b0;
        end else begin
            case (st_q)
                TKSP_ST_IDLE: begin
                    if (scl_fall) begin
                        st_q  <= TKSP_ST_DELAY;
                        cnt_q <= 32'h0;
                        bit_q <= `TKSP_BIT_START;
                        wr_q  <= ~sda2_q;
                    end
                end
                TKSP_ST_DELAY: begin
                    if (!dly_done) begin
                        cnt_q <= cnt_q + 32'h1;
                    end else begin
                        cnt_q <= 32'h0;
                        st_q  <= is_end ? TKSP_ST_IDLE : TKSP_ST_HOLD;
                        if (!wr_q) begin
                            if (is_start) begin
                                sd_q.oe <= 1'b1;
                                snap_q  <= keys_q;
                            end else if (is_end) begin
                                sd_q.oe <= 1'b0;
                            end else begin
                                // open drain: a touched key releases the line
                                sd_q.oe <= ~snap_q[idx];
                            end
                        end else if (is_end) begin
                            wr_tgl <= ~wr_tgl;
                        end else if (!is_start) begin
                            stage_q[idx] <= sda2_q;
                        end
                    end
                end
                TKSP_ST_HOLD: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        st_q  <= TKSP_ST_DELAY;
                        cnt_q <= 32'h0;
                    end else if (!scl2_q) begin
                        cnt_q <= 32'h0;
                    end else if (cnt_q == TMO_CYC - 1) begin
                        // noise recovery: stale frame dropped, line let go
                        st_q    <= TKSP_ST_IDLE;
                        sd_q.oe <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                default: begin
                    st_q    <= TKSP_ST_IDLE;
                    sd_q.oe <= 1'b0;
                end
            endcase
        end
    end

    assign wr_level    = stage_q;
    assign serial_data = sd_q;

    ////////////////////////////////////////////////////////////////////////////////
    chk_idle_release: assert property (@(posedge lclk) disable iff (!lrst_b_q)
        st_q == TKSP_ST_IDLE |-> !sd_q.oe)
        else $error("data line driven while bus idle");

    chk_ack_delay: assert property (@(posedge lclk) disable iff (!lrst_b_q)
        $rose(sd_q.oe) |-> $past(cnt_q) == ACK_CYC - 1 && $past(st_q) == TKSP_ST_DELAY)
        else $error("data line driven before the ack delay");

    chk_write_quiet: assert property (@(posedge lclk) disable iff (!lrst_b_q)
        wr_q |-> !sd_q.oe)
        else $error("data line driven during a write");

    chk_end_release: assert property (@(posedge lclk) disable iff (!lrst_b_q)
        st_q == TKSP_ST_DELAY && is_end && dly_done |=> st_q == TKSP_ST_IDLE && !sd_q.oe)
        else $error("end bit did not release the line");

    chk_commit_end: assert property (@(posedge lclk) disable iff (!lrst_b_q)
        $changed(wr_tgl) |-> $past(bit_q) == `TKSP_BIT_END && $past(wr_q))
        else $error("write committed before its end bit");

endmodule // tksp_link

// >>> hw/tksp_top.sv
`timescale 1ns/10ps
`include "tksp_regs.svh"


module tksp_top #(
    parameter int unsigned BLC_CYC    = `TKSP_BLC_MAX_MS * `TKSP_MCLK_MHZ * 1000,
    parameter int unsigned PULSE_CYC  = `TKSP_PULSE_MS * `TKSP_MCLK_MHZ * 1000,
    parameter int unsigned REINIT_CYC = `TKSP_REINIT_MS * `TKSP_MCLK_MHZ * 1000,
    parameter int unsigned TMO_CYC    = (`TKSP_BUS_IDLE_US * 1000) / `TKSP_LCLK_PERIOD_NS
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             lclk,
    input  wire logic [7:0]       key_touch,
    input  wire logic             multi_key_strap,
    input  wire logic             serial_clock_i,
    input  wire logic             serial_data_i,
    output tksp_pkg::tksp_od_t    serial_data,
    output logic                  backlight_out,
    output logic                  touch_pulse_out_b,
    output logic [7:0]            sensitivity_level,
    output logic [7:0]            touch_threshold,
    output logic                  reinit_busy
);
    import tksp_pkg::*;

    logic        ms1_q, ms2_q, multi_q, cap_q;
    logic [7:0]  prev_q, own_q, rep_q;
    logic        req_q, ack1_q, ack2_q;
    logic        w1_q, w2_q, w3_q;
    logic [7:0]  sens_q, thr_q;
    logic        reinit_q, blc_q, pls_b_q;
    logic [31:0] rcnt_q, bcnt_q, pcnt_q;
    logic        key_ack, wr_tgl;
    logic [7:0]  wr_level;

    ////////////////////////////////////////////////////////////////////////////////
    // variant strap, caught once after reset release
    always_ff @(posedge mclk) begin
        ms1_q <= multi_key_strap;
        ms2_q <= ms1_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            multi_q <= 1'b0;
            cap_q   <= 1'b0;
        end else if (!cap_q) begin
            multi_q <= ms2_q;
            cap_q   <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // key selection; front end results are not trusted while reinitialising
    wire [7:0] key_act   = reinit_q ? 8'h00 : key_touch;
    wire       any_touch = |key_act;
    wire       new_touch = |(key_act & ~prev_q);
    wire [7:0] lowest    = key_act & (~key_act + 8'h01);
    wire       own_held  = |(own_q & key_act);
    wire [7:0] seq_sel   = own_q & key_act;

    wire [3:0] pre [0:8];
    wire [7:0] multi_sel;
    assign pre[0] = 4'h0;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_multi
            assign pre[gi+1]     = pre[gi] + {3'h0, key_act[gi]};
            assign multi_sel[gi] = key_act[gi] & (pre[gi] < 4'h3);
        end
    endgenerate

    wire [7:0] report = multi_q ? multi_sel : seq_sel;

    // sequential variant: one key owns the report until it is released
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            own_q  <= 8'h00;
            prev_q <= 8'h00;
        end else begin
            prev_q <= key_act;
            if (!own_held)
                own_q <= lowest;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // key byte to the link domain; rep_q holds still while a transfer is open
    always_ff @(posedge mclk) begin
        ack1_q <= key_ack;
        ack2_q <= ack1_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rep_q <= 8'h00;
            req_q <= 1'b0;
        end else if (ack2_q == req_q) begin
            rep_q <= report;
            req_q <= ~req_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sensitivity commit from the link domain
    always_ff @(posedge mclk) begin
        w1_q <= wr_tgl;
        w2_q <= w1_q;
        w3_q <= w2_q;
    end

    wire wr_evt   = w2_q ^ w3_q;
    wire wr_valid = (wr_level >= `TKSP_SENS_MIN) && (wr_level <= `TKSP_SENS_MAX);
    wire r_last   = (rcnt_q == REINIT_CYC - 1);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sens_q   <= `TKSP_SENS_RESET;
            reinit_q <= 1'b0;
            rcnt_q   <= 32'h0;
        end else if (wr_evt && wr_valid) begin
            sens_q   <= wr_level;
            reinit_q <= 1'b1;
            rcnt_q   <= 32'h0;
        end else if (reinit_q) begin
            reinit_q <= !r_last;
            rcnt_q   <= rcnt_q + 32'h1;
        end
    end

    // a lower threshold trips on a smaller change, so more level is more sensitive
    always_ff @(posedge mclk) begin
        if (!rst_b)
            thr_q <= `TKSP_SENS_MAX + 8'h01 - `TKSP_SENS_RESET;
        else
            thr_q <= `TKSP_SENS_MAX + 8'h01 - sens_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // backlight and touch pulse
    wire b_last = (bcnt_q == BLC_CYC - 1);
    wire p_last = (pcnt_q == PULSE_CYC - 1);

    always_ff @(posedge mclk) begin
        if (!rst_b || !any_touch) begin
            blc_q  <= 1'b0;
            bcnt_q <= 32'h0;
        end else if (b_last) begin
            blc_q  <= 1'b0;
        end else begin
            blc_q  <= 1'b1;
            bcnt_q <= bcnt_q + 32'h1;
        end
    end

    // one fixed pulse per new touch that comes while no pulse runs; holding a key does not stretch it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pls_b_q <= 1'b1;
            pcnt_q  <= 32'h0;
        end else if (pls_b_q) begin
            pcnt_q <= 32'h0;
            if (new_touch)
                pls_b_q <= 1'b0;
        end else begin
            pcnt_q <= pcnt_q + 32'h1;
            if (p_last)
                pls_b_q <= 1'b1;
        end
    end

    assign backlight_out     = blc_q;
    assign touch_pulse_out_b = pls_b_q;
    assign sensitivity_level = sens_q;
    assign touch_threshold   = thr_q;
    assign reinit_busy       = reinit_q;

    ////////////////////////////////////////////////////////////////////////////////
    tksp_link #(
        .TMO_CYC        (TMO_CYC)
    ) u_link (
        .lclk           (lclk),
        .rst_b          (rst_b),
        .serial_clock_i (serial_clock_i),
        .serial_data_i  (serial_data_i),
        .key_req_tgl    (req_q),
        .key_data       (rep_q),
        .key_ack_tgl    (key_ack),
        .wr_tgl         (wr_tgl),
        .wr_level       (wr_level),
        .serial_data    (serial_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    chk_blc_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        !any_touch |=> !backlight_out)
        else $error("backlight on with no touch");

    chk_blc_timeout: assert property (@(posedge mclk) disable iff (!rst_b)
        b_last && any_touch |=> !backlight_out ##1 !backlight_out)
        else $error("backlight outlived its limit");

    chk_pulse_start: assert property (@(posedge mclk) disable iff (!rst_b)
        new_touch && touch_pulse_out_b |=> !touch_pulse_out_b)
        else $error("touch pulse not started");

    chk_pulse_len: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(touch_pulse_out_b) |-> $past(pcnt_q) == PULSE_CYC - 1)
        else $error("touch pulse length wrong");

    chk_reject_bad: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_evt && !wr_valid && !reinit_q |=> $stable(sens_q) && !reinit_q)
        else $error("invalid level was applied");

    chk_apply_good: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_evt && wr_valid |=> sens_q == $past(wr_level) && reinit_q)
        else $error("valid level not applied");

    chk_reinit_len: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(reinit_q) |-> $past(rcnt_q) == REINIT_CYC - 1)
        else $error("reinit length wrong");

    chk_multi_three: assert property (@(posedge mclk) disable iff (!rst_b)
        multi_q |-> $countones(report) <= 3)
        else $error("more than three keys reported");

    chk_seq_one: assert property (@(posedge mclk) disable iff (!rst_b)
        !multi_q |-> $countones(report) <= 1)
        else $error("sequential mode reported two keys");

    chk_reinit_mute: assert property (@(posedge mclk) disable iff (!rst_b)
        reinit_q |=> !backlight_out)
        else $error("keys live during reinit");

    ////////////////////////////////////////////////////////////////////////////////
    // level, threshold, backlight, pulse, key report and reinit invariants
    chk_level_boot: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(rst_b) |-> sens_q == `TKSP_SENS_RESET && !reinit_q)
        else $error("level not at its power-up value");

    chk_level_range: assert property (@(posedge mclk) disable iff (!rst_b)
        sensitivity_level >= `TKSP_SENS_MIN && sensitivity_level <= `TKSP_SENS_MAX)
        else $error("active level out of range");

    chk_level_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !wr_evt |=> $stable(sens_q))
        else $error("level moved without a commit");

    chk_thr_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        sens_q > $past(sens_q) |=> touch_threshold < $past(touch_threshold))
        else $error("higher level did not lower the threshold");

    chk_blc_on: assert property (@(posedge mclk) disable iff (!rst_b)
        any_touch && bcnt_q == 32'h0 |=> backlight_out)
        else $error("backlight missed a new touch");

    chk_pulse_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        !touch_pulse_out_b && !p_last |=> !touch_pulse_out_b)
        else $error("touch pulse cut short");

    chk_seq_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        !multi_q && own_held |=> $stable(own_q))
        else $error("held key lost the report");

    chk_multi_all: assert property (@(posedge mclk) disable iff (!rst_b)
        multi_q && $countones(key_act) <= 3 |-> report == key_act)
        else $error("held keys missing from report");

    chk_key_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
        req_q != ack2_q |=> $stable(rep_q))
        else $error("key byte changed during a transfer");

    chk_reinit_end: assert property (@(posedge mclk) disable iff (!rst_b)
        reinit_q && r_last && !wr_evt |=> !reinit_busy)
        else $error("reinit overran");

endmodule // tksp_top

// >>> pkg/tksp_pkg.sv
package tksp_pkg;

    // open-drain pin as driven by the device: level and enable
    typedef struct packed {
        logic o;
        logic oe;
    } tksp_od_t;

    typedef enum logic [2:0] {
        TKSP_ST_IDLE  = 3'b001,
        TKSP_ST_DELAY = 3'b010,
        TKSP_ST_HOLD  = 3'b100
    } tksp_lstate_t;

endpackage

// >>> pkg/tksp_regs.svh
`ifndef TKSP_REGS_SVH
`define TKSP_REGS_SVH

// clock rates
`define TKSP_MCLK_MHZ        100
`define TKSP_LCLK_PERIOD_NS  32

// sensitivity level limits and power-up value
`define TKSP_SENS_RESET      8'h1d
`define TKSP_SENS_MIN        8'h01
`define TKSP_SENS_MAX        8'h20

// timing figures in their own units
`define TKSP_BLC_MAX_MS      9000
`define TKSP_PULSE_MS        50
`define TKSP_REINIT_MS       50
`define TKSP_ACK_MIN_NS      10000
`define TKSP_BUS_IDLE_US     2000

// serial frame layout
`define TKSP_BIT_START       4'h0
`define TKSP_BIT_END         4'h9

`endif

// >>> sim/tb_touch_key_serial_port.sv
`timescale 1ns/10ps

module tb_touch_key_serial_port;
    import tksp_pkg::*;

    localparam int BACKLIGHT_OUT    = 2000;
    localparam int PULSE  = 300;
    localparam int REINIT = 500;
    localparam int TMO    = 500;

    logic       mclk;
    logic       lclk;
    logic       rst_b;
    logic       strap;
    logic [7:0] key_touch;
    tksp_od_t   sd;
    logic       bl;
    logic       pulse_b;
    logic [7:0] level;
    logic [7:0] thr;
    logic       busy;
    logic       h_clk_low;
    logic       h_dat_low;
    int         fail_count;
    int         samples_checked;
    wire        sclk_wire = ~h_clk_low;
    wire        sdat_wire = ~(h_dat_low | (sd.oe & ~sd.o));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    initial begin
        lclk = 1'b0;
        #7;
        forever #16 lclk = ~lclk;
    end

    tksp_top #(.BLC_CYC(BACKLIGHT_OUT), .PULSE_CYC(PULSE), .REINIT_CYC(REINIT), .TMO_CYC(TMO)) dut (
        .mclk(mclk), .rst_b(rst_b), .lclk(lclk), .key_touch(key_touch),
        .multi_key_strap(strap), .serial_clock_i(sclk_wire), .serial_data_i(sdat_wire),
        .serial_data(sd), .backlight_out(bl), .touch_pulse_out_b(pulse_b),
        .sensitivity_level(level), .touch_threshold(thr), .reinit_busy(busy)
    );

    tksp_host host (.mclk(mclk), .data_wire(sdat_wire), .clk_low(h_clk_low), .data_low(h_dat_low));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bad(input string m);
        fail_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    function automatic bit cmp(input bit mis);
        samples_checked++;
        return mis;
    endfunction

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic mode);
        @(negedge mclk);
        rst_b = 1'b0;
        strap = mode;
        key_touch = 8'h00;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        repeat (20) @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        if (cmp(level !== 8'h1d)) bad("power-up level");
        if (cmp(thr !== 8'h04)) bad("power-up threshold");
        if (cmp(sd.oe !== 1'b0 || bl !== 1'b0 || pulse_b !== 1'b1)) bad("idle outputs");
    endtask

    task automatic t_pulse_backlight();
        int   lo;
        logic bl_on;
        logic bl_mid;
        lo = 0;
        key_touch = 8'h01;
        for (int i = 0; i < BACKLIGHT_OUT + 20; i++) begin
            @(negedge mclk);
            if (pulse_b === 1'b0) lo++;
            if (i == 4) bl_on = bl;
            if (i == BACKLIGHT_OUT - 20) bl_mid = bl;
        end
        // touch is still held here, so the pulse must not follow its length
        if (cmp(lo != PULSE)) bad("pulse length");
        if (cmp(bl_on !== 1'b1 || bl_mid !== 1'b1)) bad("backlight while touched");
        if (cmp(bl !== 1'b0)) bad("backlight time limit");
        key_touch = 8'h00;
        repeat (5) @(negedge mclk);
        key_touch = 8'h08;
        repeat (5) @(negedge mclk);
        if (cmp(bl !== 1'b1)) bad("backlight on new touch");
        key_touch = 8'h00;
        repeat (5) @(negedge mclk);
        if (cmp(bl !== 1'b0)) bad("backlight on release");
    endtask

    task automatic t_read(input logic [7:0] touch, input logic [7:0] want);
        logic       ack;
        logic [7:0] keys;
        key_touch = touch;
        repeat (100) @(negedge mclk);
        host.read_keys(ack, keys);
        if (cmp(ack !== 1'b1)) bad("start acknowledge");
        if (cmp(keys !== want)) bad("key byte");
        if (cmp(sd.oe !== 1'b0)) bad("data kept after end bit");
        key_touch = 8'h00;
    endtask

    task automatic t_timeout();
        host.start_only();
        if (cmp(sd.oe !== 1'b1)) bad("acknowledge not held");
        repeat (TMO * 32 / 10 + 500) @(negedge mclk);
        if (cmp(sd.oe !== 1'b0)) bad("stale frame kept");
    endtask

    task automatic t_write(input logic [7:0] lvl, input logic ok);
        logic [7:0] old;
        int         hi;
        int         early;
        int         drv;
        old = level;
        hi = 0;
        early = 0;
        drv = 0;
        fork
            host.write_level(lvl);
            for (int i = 0; i < 23200; i++) begin
                @(negedge mclk);
                if (busy === 1'b1) hi++;
                if (hi == 0 && level !== old) early++;
                if (sd.oe === 1'b1) drv++;
            end
        join
        if (cmp(early != 0)) bad("level moved before end bit");
        if (cmp(drv != 0)) bad("data driven during write");
        if (ok) begin
            if (cmp(hi != REINIT)) bad("reinit length");
            if (cmp(level !== lvl)) bad("level not applied");
            if (cmp(thr !== 8'h21 - lvl || thr >= 8'h04)) bad("threshold");
        end else begin
            if (cmp(hi != 0 || level !== old)) bad("out-of-range level taken");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        strap = 1'b0;
        key_touch = 8'h00;
        do_reset(1'b0);
        t_reset_values();
        t_pulse_backlight();
        t_read(8'h06, 8'h02);
        t_timeout();
        t_write(8'h21, 1'b0);
        t_write(8'h20, 1'b1); // only accepted write of the run
        repeat (REINIT + 100) @(negedge mclk); // bus left alone after the reinit has run out
        do_reset(1'b1);
        t_reset_values(); // mid-run reset restores power-up state
        t_read(8'h2b, 8'h0b);
        stop_test();
    end

    // the scenarios need about 100000 cycles
    initial begin
        repeat (120000) @(posedge mclk);
        bad("run did not finish");
        stop_test();
    end

endmodule // tb_touch_key_serial_port

// >>> sim/tksp_host.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// host side of the two-wire port; both lines are open-drain with pull-ups
module tksp_host #(
    parameter int LOW_CYC  = 2250,
    parameter int HIGH_CYC = 50
) (
    input  wire logic mclk,
    input  wire logic data_wire,
    output logic      clk_low,
    output logic      data_low
);

    initial begin
        clk_low  = 1'b0;
        data_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // low phase stays above the answer window; the high phase is kept short to
    // hold the run length down, so the bit rate sits above the usual host range
    task automatic bit_pulse(output logic smp);
        clk_low = 1'b1;
        repeat (LOW_CYC) @(negedge mclk);
        smp = data_wire; // sampled before the clock rises
        clk_low = 1'b0;
        repeat (HIGH_CYC) @(negedge mclk);
    endtask

    task automatic read_keys(output logic ack, output logic [7:0] keys);
        logic s;
        data_low = 1'b0; // released data selects a read
        bit_pulse(s);
        ack = ~s;
        for (int k = 0; k < 8; k++) begin
            bit_pulse(s);
            keys[k] = s; // channel zero comes first
        end
        bit_pulse(s); // end bit, ten pulses in all
    endtask

    task automatic write_level(input logic [7:0] lvl);
        logic s;
        data_low = 1'b1; // data low before the clock falls
        repeat (10) @(negedge mclk);
        bit_pulse(s);
        for (int k = 0; k < 8; k++) begin
            data_low = ~lvl[k]; // bit set up ahead of the fall
            repeat (10) @(negedge mclk);
            bit_pulse(s);
        end
        data_low = 1'b0; // data released for the end bit
        repeat (10) @(negedge mclk);
        bit_pulse(s);
    endtask

    // abandons a read right after its start bit
    task automatic start_only();
        logic s;
        data_low = 1'b0;
        bit_pulse(s);
    endtask

endmodule // tksp_host
